// File: core/accessory_detect_midrail_ctrl_defines.vh
`ifndef ACCESSORY_DETECT_MIDRAIL_CTRL_DEFINES_VH
`define ACCESSORY_DETECT_MIDRAIL_CTRL_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_POWER_MANAGEMENT_ONE 8'h08
`define IDX_MIC_BIAS_CONTROL     8'h4a
`define IDX_JACK_DETECT_CONTROL  8'h4d
`define IDX_ANTI_POP_CONTROL     8'h4e
`define IDX_EVENT_STATUS         8'h60

// Field positions, power_management_one
`define PM1_MIC_SENSE_BIT        8
`define PM1_STRING_EN_BIT        2
`define PM1_DIVIDER_HI           1
`define PM1_DIVIDER_LO           0
// Field positions, mic_bias_control
`define MBC_MIC_SENSE_BIT        7
`define MBC_PLUG_THR_HI          4
`define MBC_PLUG_THR_LO          2
`define MBC_SHORT_THR_HI         1
`define MBC_SHORT_THR_LO         0
// Field positions, jack_detect_control
`define JDC_LEFT_EN_BIT          15
`define JDC_RIGHT_EN_BIT         14
// Field positions, anti_pop_control
`define APC_SPEED_HI             9
`define APC_SPEED_LO             8
// Field positions, event_status (pending 3:0, live 7:4)
`define EVS_LEFT_JACK_BIT        0
`define EVS_RIGHT_JACK_BIT       1
`define EVS_MIC_INSERT_BIT       2
`define EVS_MIC_SHORT_BIT        3
`define EVS_LIVE_LO              4

// Reset values
`define RST_PLUG_THR             3'h0
`define RST_SHORT_THR            2'h0
`define RST_DIVIDER              2'h0
`define RST_RAMP_SPEED           2'h0

// Divider and ramp speed codes
`define DIVIDER_OFF              2'h0
`define RAMP_NONE                2'h0
`define RAMP_FAST                2'h1
`define RAMP_MEDIUM              2'h2

// Ramp step lengths in 100 MHz core cycles: 1 us, 4 us, 16 us
`define RAMP_STEP_FAST_CYC       16'h0064
`define RAMP_STEP_MEDIUM_CYC     16'h0190
`define RAMP_STEP_SLOW_CYC       16'h0640

`endif

// File: core/accessory_detect_midrail_ctrl.v
// How it works
// - Jack register bit 15 enables left second-input jack sensing, reset 0.
// - Jack register bit 14 enables right second-input jack sensing, reset 0.
// - Enabled side reports its jack socket state through its own event.
// - Bias current above plug-in threshold raises the microphone insert event.
// - Bias current above short limit raises a separate microphone short event.
// - Plug-in threshold is mic bias bits 4:2, reset 000, 160 to 1400 uA.
// - Short threshold is mic bias bits 1:0, reset 00, 400 to 1800 uA.
// - Microphone sense enable is one bit, seen at power bit 8 and bias bit 7.
// - Power register bit 2 enables the mid-rail string, reset 0.
// - Power bits 1:0 pick the divider: off, 300k, 50k, 5k; reset off.
// - Mid-rail start and stop ramp softly at the anti-pop speed; speed none jumps in one edge.
// - Anti-pop speed bits 9:8, reset 00: none, fast, medium, slow.
`timescale 1ns/1ps
`default_nettype none
`include "accessory_detect_midrail_ctrl_defines.vh"

module accessory_detect_midrail_ctrl #(
  parameter RAMP_BITS = 8
) (
  input  wire                 sys_clk_i,
  input  wire                 sys_rst_i,
  input  wire [9:0]           avs_address_i,
  input  wire                 avs_read_i,
  input  wire                 avs_write_i,
  input  wire [31:0]          avs_writedata_i,
  input  wire [3:0]           avs_byteenable_i,
  output wire [31:0]          avs_readdata_o,
  output wire                 avs_waitrequest_o,
  input  wire                 left_second_input_pin_i,
  input  wire                 right_second_input_pin_i,
  input  wire                 mic_above_plug_threshold_i,
  input  wire                 mic_above_short_threshold_i,
  output wire                 left_jack_sense_enable_o,
  output wire                 right_jack_sense_enable_o,
  output wire                 microphone_sense_enable_o,
  output wire [2:0]           plug_in_current_threshold_o,
  output wire [1:0]           short_circuit_current_threshold_o,
  output wire                 midrail_string_enable_o,
  output wire [1:0]           midrail_divider_select_o,
  output wire [RAMP_BITS-1:0] midrail_ramp_level_o,
  output wire                 midrail_ramping_o,
  output wire                 left_jack_event_o,
  output wire                 right_jack_event_o,
  output wire                 microphone_insert_event_o,
  output wire                 microphone_short_event_o
);

  // Full-scale ramp level and step lengths in core cycles
  localparam [RAMP_BITS-1:0] RAMP_TOP = {RAMP_BITS{1'b1}};
  localparam [15:0] STEP_FAST = `RAMP_STEP_FAST_CYC;
  localparam [15:0] STEP_MED  = `RAMP_STEP_MEDIUM_CYC;
  localparam [15:0] STEP_SLOW = `RAMP_STEP_SLOW_CYC;

  // Bus handshake and read data
  reg                  ack_r;
  reg  [31:0]          rdata_r;

  // Control fields
  reg                  left_en_r;
  reg                  right_en_r;
  reg                  mic_en_r;
  reg  [2:0]           plug_thr_r;
  reg  [1:0]           short_thr_r;
  reg                  string_en_r;
  reg  [1:0]           divider_r;
  reg  [1:0]           ramp_speed_r;

  // Pin synchronisers, edge memory and pending events
  reg  [3:0]           sync1_r;
  reg  [3:0]           sync2_r;
  reg  [3:0]           prev_r;
  reg  [3:0]           pending_r;

  // Mid-rail ramp
  reg  [RAMP_BITS-1:0] level_r;
  reg  [15:0]          step_cnt_r;

  // Combinational helpers, assigned in always @*
  reg  [31:0]          rdata_nxt;
  reg  [15:0]          step_len;

  // Word decode; the two low byte-address bits are ignored
  wire [7:0]  idx      = avs_address_i[9:2];
  wire        wr_fire  = avs_write_i & ack_r;
  wire [15:0] wd       = avs_writedata_i[15:0];
  wire        be_lo    = avs_byteenable_i[0];
  wire        be_hi    = avs_byteenable_i[1];
  wire        wr_pm1   = wr_fire & (idx == `IDX_POWER_MANAGEMENT_ONE);
  wire        wr_mbc   = wr_fire & (idx == `IDX_MIC_BIAS_CONTROL);
  wire        wr_jdc   = wr_fire & (idx == `IDX_JACK_DETECT_CONTROL);
  wire        wr_apc   = wr_fire & (idx == `IDX_ANTI_POP_CONTROL);
  wire        wr_evs   = wr_fire & (idx == `IDX_EVENT_STATUS) & be_lo;

  // Per-event enables; mic sense arms both microphone events
  wire [3:0]  arm      = {mic_en_r, mic_en_r, right_en_r, left_en_r};
  wire [3:0]  hit;

  // One wait cycle per access keeps decode and read data registered
  // Back-to-back requests each pay the same single wait state
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // Read mux; unmapped and reserved bits read zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (idx)
      `IDX_POWER_MANAGEMENT_ONE:
      begin
        rdata_nxt[`PM1_MIC_SENSE_BIT] = mic_en_r;
        rdata_nxt[`PM1_STRING_EN_BIT] = string_en_r;
        rdata_nxt[`PM1_DIVIDER_HI:`PM1_DIVIDER_LO] = divider_r;
      end
      `IDX_MIC_BIAS_CONTROL:
      begin
        rdata_nxt[`MBC_MIC_SENSE_BIT] = mic_en_r;
        rdata_nxt[`MBC_PLUG_THR_HI:`MBC_PLUG_THR_LO] = plug_thr_r;
        rdata_nxt[`MBC_SHORT_THR_HI:`MBC_SHORT_THR_LO] = short_thr_r;
      end
      `IDX_JACK_DETECT_CONTROL:
      begin
        rdata_nxt[`JDC_LEFT_EN_BIT]  = left_en_r;
        rdata_nxt[`JDC_RIGHT_EN_BIT] = right_en_r;
      end
      `IDX_ANTI_POP_CONTROL:
        rdata_nxt[`APC_SPEED_HI:`APC_SPEED_LO] = ramp_speed_r;
      // Pending flags low, live synchronised levels above them
      `IDX_EVENT_STATUS:
      begin
        rdata_nxt[3:0] = pending_r;
        rdata_nxt[`EVS_LIVE_LO+3:`EVS_LIVE_LO] = sync2_r;
      end
      // Unmapped index reads zero and still takes one wait state
      default:
        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Capture read data on the same edge that drops waitrequest
  // Old data stays between reads, so a slow master never sees it move
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_i & ~ack_r)
      rdata_r <= rdata_nxt;
  end

  // Control registers, written per byte lane
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      left_en_r    <= 1'b0;
      right_en_r   <= 1'b0;
      mic_en_r     <= 1'b0;
      plug_thr_r   <= `RST_PLUG_THR;
      short_thr_r  <= `RST_SHORT_THR;
      string_en_r  <= 1'b0;
      divider_r    <= `RST_DIVIDER;
      ramp_speed_r <= `RST_RAMP_SPEED;
    end
    else
    begin
      // Mic sense is one bit behind two addresses; power register first
      if (wr_pm1 & be_hi)
        mic_en_r <= wd[`PM1_MIC_SENSE_BIT];
      else if (wr_mbc & be_lo)
        mic_en_r <= wd[`MBC_MIC_SENSE_BIT];
      // String enable and divider share the low lane
      if (wr_pm1 & be_lo)
      begin
        string_en_r <= wd[`PM1_STRING_EN_BIT];
        divider_r   <= wd[`PM1_DIVIDER_HI:`PM1_DIVIDER_LO];
      end
      if (wr_mbc & be_lo)
      begin
        plug_thr_r  <= wd[`MBC_PLUG_THR_HI:`MBC_PLUG_THR_LO];
        short_thr_r <= wd[`MBC_SHORT_THR_HI:`MBC_SHORT_THR_LO];
      end
      if (wr_jdc & be_hi)
      begin
        left_en_r  <= wd[`JDC_LEFT_EN_BIT];
        right_en_r <= wd[`JDC_RIGHT_EN_BIT];
      end
      // Only the speed field of the anti-pop word is kept
      if (wr_apc & be_hi)
        ramp_speed_r <= wd[`APC_SPEED_HI:`APC_SPEED_LO];
    end
  end

  // Comparator and pin levels are asynchronous: two flops first
  // Comparators may chatter near a threshold; each upward crossing counts
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r  <= 4'h0;
    end
    else
    begin
      sync1_r <= {mic_above_short_threshold_i, mic_above_plug_threshold_i,
                  right_second_input_pin_i, left_second_input_pin_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Jack events on any socket change; mic events on rising current only
  // Enables gate edges, so sensing turned on with a jack present stays quiet
  assign hit[0] = arm[0] & (sync2_r[0] ^ prev_r[0]);
  assign hit[1] = arm[1] & (sync2_r[1] ^ prev_r[1]);
  assign hit[2] = arm[2] & sync2_r[2] & ~prev_r[2];
  assign hit[3] = arm[3] & sync2_r[3] & ~prev_r[3];

  // Sticky pending flags, write one to clear; a new hit beats the clear
  // Clear bits above the four flags are ignored
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pend
      always @(posedge sys_clk_i)
      begin
        if (sys_rst_i)
          pending_r[g] <= 1'b0;
        else if (hit[g])
          pending_r[g] <= 1'b1;
        else if (wr_evs & wd[g])
          pending_r[g] <= 1'b0;
      end
    end
  endgenerate

  // Step interval per anti-pop speed
  // Code 11 and anything unexpected take the slowest curve
  always @*
  begin
    case (ramp_speed_r)
      `RAMP_FAST:   step_len = STEP_FAST;
      `RAMP_MEDIUM: step_len = STEP_MED;
      default:      step_len = STEP_SLOW;
    endcase
  end

  // Linear ramp of mid-rail level, one count per step; no ramp jumps straight to target (pops)
  // Ramp rises only with the string on and a divider chosen
  // No slow-clock gating here; software keeps that clock running
  wire       vmid_on    = string_en_r & (divider_r != `DIVIDER_OFF);
  wire [RAMP_BITS-1:0] target = vmid_on ? RAMP_TOP : {RAMP_BITS{1'b0}};
  wire       at_target  = (level_r == target);

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      level_r    <= {RAMP_BITS{1'b0}};
      step_cnt_r <= 16'h0000;
    end
    else if (at_target)
      step_cnt_r <= 16'h0000;
    // Speed 00 lands in one edge and will pop
    else if (ramp_speed_r == `RAMP_NONE)
      level_r <= target;
    else if (step_cnt_r >= step_len - 16'h0001)
    begin
      step_cnt_r <= 16'h0000;
      level_r    <= vmid_on ? level_r + 1'b1 : level_r - 1'b1;
    end
    else
      step_cnt_r <= step_cnt_r + 16'h0001;
  end

  // Outputs straight from registers, except the ramping status
  assign left_jack_sense_enable_o          = left_en_r;
  assign right_jack_sense_enable_o         = right_en_r;
  assign microphone_sense_enable_o         = mic_en_r;
  assign plug_in_current_threshold_o       = plug_thr_r;
  assign short_circuit_current_threshold_o = short_thr_r;
  assign midrail_string_enable_o           = string_en_r;
  assign midrail_divider_select_o          = divider_r;
  assign midrail_ramp_level_o              = level_r;
  assign midrail_ramping_o                 = ~at_target;
  assign left_jack_event_o                 = pending_r[0];
  assign right_jack_event_o                = pending_r[1];
  assign microphone_insert_event_o         = pending_r[2];
  assign microphone_short_event_o          = pending_r[3];

endmodule // accessory_detect_midrail_ctrl
`default_nettype wire

// File: verification/adm_props.sv
`timescale 1ns/1ps
`default_nettype none
module adm_props (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        left_jack_sense_enable_o,
  input wire logic        right_jack_sense_enable_o,
  input wire logic        microphone_sense_enable_o,
  input wire logic [2:0]  plug_in_current_threshold_o,
  input wire logic        midrail_string_enable_o,
  input wire logic [1:0]  midrail_divider_select_o,
  input wire logic        left_jack_event_o,
  input wire logic        microphone_insert_event_o,
  input wire logic        microphone_short_event_o
);
  // Index of the write taken at this edge; 0 is unmapped, so it stands for none
  logic [7:0]  wi;
  logic [3:0]  be;
  logic [15:0] wd;
  assign wi = (avs_write_i && !avs_waitrequest_o) ? avs_address_i[9:2] : 8'h00;
  assign be = avs_byteenable_i;
  assign wd = avs_writedata_i[15:0];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_left_en; wi == 8'h4d && be[1] |=> left_jack_sense_enable_o == $past(wd[15]); endproperty
  a_left_en: assert property (p_left_en) else $error("left jack enable not stored");
  property p_right_en; wi == 8'h4d && be[1] |=> right_jack_sense_enable_o == $past(wd[14]); endproperty
  a_right_en: assert property (p_right_en) else $error("right jack enable not stored");
  property p_short_gate; $rose(microphone_short_event_o) |-> $past(microphone_sense_enable_o); endproperty
  a_short_gate: assert property (p_short_gate) else $error("short event while sensing off");
  property p_mic_pm; wi == 8'h08 && be[1] |=> microphone_sense_enable_o == $past(wd[8]); endproperty
  a_mic_pm: assert property (p_mic_pm) else $error("mic enable missed power write");
  property p_mic_mb; wi == 8'h4a && be[0] |=> microphone_sense_enable_o == $past(wd[7]); endproperty
  a_mic_mb: assert property (p_mic_mb) else $error("mic enable missed bias write");
  property p_plug; wi == 8'h4a && be[0] |=> plug_in_current_threshold_o == $past(wd[4:2]); endproperty
  a_plug: assert property (p_plug) else $error("plug threshold not stored");
  property p_mid; wi == 8'h08 && be[0] |=> {midrail_string_enable_o, midrail_divider_select_o} == $past(wd[2:0]);
  endproperty
  a_mid: assert property (p_mid) else $error("mid-rail fields not stored");
  property p_hold; left_jack_event_o && !(wi == 8'h60 && be[0] && wd[0]) |=> left_jack_event_o; endproperty
  a_hold: assert property (p_hold) else $error("pending jack event lost");
  property p_jack_gate; $rose(left_jack_event_o) |-> $past(left_jack_sense_enable_o); endproperty
  a_jack_gate: assert property (p_jack_gate) else $error("jack event while sensing off");
  property p_mic_gate; $rose(microphone_insert_event_o) |-> $past(microphone_sense_enable_o); endproperty
  a_mic_gate: assert property (p_mic_gate) else $error("mic event while sensing off");
  c_jack: cover property (left_jack_event_o && left_jack_sense_enable_o);
  c_mic: cover property ($rose(microphone_insert_event_o));
  c_clear: cover property ($fell(left_jack_event_o));
endmodule // adm_props
bind accessory_detect_midrail_ctrl adm_props u_adm_props (
  .sys_clk_i                   (sys_clk_i),
  .sys_rst_i                   (sys_rst_i),
  .avs_address_i               (avs_address_i),
  .avs_write_i                 (avs_write_i),
  .avs_writedata_i             (avs_writedata_i),
  .avs_byteenable_i            (avs_byteenable_i),
  .avs_waitrequest_o           (avs_waitrequest_o),
  .left_jack_sense_enable_o    (left_jack_sense_enable_o),
  .right_jack_sense_enable_o   (right_jack_sense_enable_o),
  .microphone_sense_enable_o   (microphone_sense_enable_o),
  .plug_in_current_threshold_o (plug_in_current_threshold_o),
  .midrail_string_enable_o     (midrail_string_enable_o),
  .midrail_divider_select_o    (midrail_divider_select_o),
  .left_jack_event_o           (left_jack_event_o),
  .microphone_insert_event_o   (microphone_insert_event_o),
  .microphone_short_event_o    (microphone_short_event_o)
);
`default_nettype wire

// File: verification/jack_mic_model.sv
`timescale 1ns/1ps
`default_nettype none
module jack_mic_model (
  input  wire logic [2:0]  plug_thr_i,
  input  wire logic [1:0]  short_thr_i,
  input  wire logic        jack_l_i,
  input  wire logic        jack_r_i,
  input  wire logic [11:0] bias_ua_i,
  output logic             left_pin_o,
  output logic             right_pin_o,
  output logic             above_plug_o,
  output logic             above_short_o
);
  // Threshold currents by code; the wide analogue tolerance is not modelled
  localparam int PLUG_UA [8] = '{160, 330, 500, 680, 850, 1000, 1200, 1400};
  localparam int SHORT_UA [4] = '{400, 900, 1350, 1800};
  // Socket switches and current comparators, no sync to the core clock
  assign left_pin_o = jack_l_i;
  assign right_pin_o = jack_r_i;
  assign above_plug_o = int'(bias_ua_i) > PLUG_UA[plug_thr_i];
  assign above_short_o = int'(bias_ua_i) > SHORT_UA[short_thr_i];
endmodule // jack_mic_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [9:0] PM = 10'h020, MB = 10'h128, JD = 10'h134, AP = 10'h138, EV = 10'h180;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic avs_waitrequest_o, left_second_input_pin_i, right_second_input_pin_i;
  logic mic_above_plug_threshold_i, mic_above_short_threshold_i, left_jack_sense_enable_o;
  logic right_jack_sense_enable_o, microphone_sense_enable_o, midrail_string_enable_o, midrail_ramping_o;
  logic left_jack_event_o, right_jack_event_o, microphone_insert_event_o, microphone_short_event_o;
  logic [2:0] plug_in_current_threshold_o;
  logic [1:0] short_circuit_current_threshold_o, midrail_divider_select_o;
  logic [7:0] midrail_ramp_level_o;
  logic jack_l = 1'b0, jack_r = 1'b0;
  logic [11:0] bias_ua = 12'd0;
  int n_mismatch = 0, check_count = 0, n;
  logic [9:0] regs [6] = '{PM, MB, JD, AP, EV, 10'h3fc};
  accessory_detect_midrail_ctrl u_accessory_detect_midrail_ctrl (
    .sys_clk_i                         (sys_clk_i),
    .sys_rst_i                         (sys_rst_i),
    .avs_address_i                     (avs_address_i),
    .avs_read_i                        (avs_read_i),
    .avs_write_i                       (avs_write_i),
    .avs_writedata_i                   (avs_writedata_i),
    .avs_byteenable_i                  (avs_byteenable_i),
    .avs_readdata_o                    (avs_readdata_o),
    .avs_waitrequest_o                 (avs_waitrequest_o),
    .left_second_input_pin_i           (left_second_input_pin_i),
    .right_second_input_pin_i          (right_second_input_pin_i),
    .mic_above_plug_threshold_i        (mic_above_plug_threshold_i),
    .mic_above_short_threshold_i       (mic_above_short_threshold_i),
    .left_jack_sense_enable_o          (left_jack_sense_enable_o),
    .right_jack_sense_enable_o         (right_jack_sense_enable_o),
    .microphone_sense_enable_o         (microphone_sense_enable_o),
    .plug_in_current_threshold_o       (plug_in_current_threshold_o),
    .short_circuit_current_threshold_o (short_circuit_current_threshold_o),
    .midrail_string_enable_o           (midrail_string_enable_o),
    .midrail_divider_select_o          (midrail_divider_select_o),
    .midrail_ramp_level_o              (midrail_ramp_level_o),
    .midrail_ramping_o                 (midrail_ramping_o),
    .left_jack_event_o                 (left_jack_event_o),
    .right_jack_event_o                (right_jack_event_o),
    .microphone_insert_event_o         (microphone_insert_event_o),
    .microphone_short_event_o          (microphone_short_event_o)
  );
  jack_mic_model u_jack_mic_model (
    .plug_thr_i    (plug_in_current_threshold_o),
    .short_thr_i   (short_circuit_current_threshold_o),
    .jack_l_i      (jack_l),
    .jack_r_i      (jack_r),
    .bias_ua_i     (bias_ua),
    .left_pin_o    (left_second_input_pin_i),
    .right_pin_o   (right_second_input_pin_i),
    .above_plug_o  (mic_above_plug_threshold_i),
    .above_short_o (mic_above_short_threshold_i)
  );
  // Free-running core clock
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; a spare edge after release keeps drivers single per step
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d, input logic [3:0] be);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    // Waitrequest is seen as it stood at each rising edge
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 20)
    begin
      @(posedge sys_clk_i);
      k++;
    end
    if (avs_waitrequest_o !== 1'b0)
    begin
      n_mismatch++;
      end_sim;
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0, 4'h3);
    check(q, e);
  endtask
  // Synchroniser plus pending flop, with margin
  task automatic settle;
    repeat (5) @(posedge sys_clk_i);
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    foreach (regs[i]) rd(regs[i], 32'h0);
    // Mic enable is one bit behind two addresses
    wr(PM, 16'h0100, 4'h2);
    check(32'(microphone_sense_enable_o), 32'h1);
    rd(MB, 32'h80);
    wr(MB, 16'h0000, 4'h1);
    rd(PM, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(MB, {11'h0, c[2:0], c[1:0]}, 4'h1);
      check(32'(plug_in_current_threshold_o), 32'(c));
      check(32'(short_circuit_current_threshold_o), 32'(c % 4));
    end
    // Slow clock taken as running, which software must see to
    wr(MB, 16'h008d, 4'h1);
    bias_ua <= 12'd600;
    settle;
    rd(EV, 32'h0);
    bias_ua <= 12'd700;
    settle;
    rd(EV, 32'h44);
    bias_ua <= 12'd1000;
    settle;
    rd(EV, 32'hcc);
    check(32'({microphone_short_event_o, microphone_insert_event_o}), 32'h3);
    bias_ua <= 12'd0;
    settle;
    rd(EV, 32'h0c);
    wr(EV, 16'h000c, 4'h1);
    rd(EV, 32'h0);
    // Jack edges are ignored until sensing is on
    jack_l <= 1'b1;
    settle;
    rd(EV, 32'h10);
    wr(JD, 16'hc000, 4'h2);
    wr(JD, 16'h0000, 4'h1);
    rd(JD, 32'hc000);
    check(32'({left_jack_sense_enable_o, right_jack_sense_enable_o}), 32'h3);
    jack_l <= 1'b0;
    jack_r <= 1'b1;
    settle;
    rd(EV, 32'h23);
    check(32'({right_jack_event_o, left_jack_event_o}), 32'h3);
    wr(EV, 16'h0001, 4'h1);
    rd(EV, 32'h22);
    // Medium divider while active; no ramp means a jump
    wr(PM, 16'h0006, 4'h1);
    check(32'({midrail_string_enable_o, midrail_divider_select_o}), 32'h6);
    settle;
    check(32'({midrail_ramping_o, midrail_ramp_level_o}), 32'h0ff);
    wr(AP, 16'h0100, 4'h2);
    rd(AP, 32'h100);
    wr(PM, 16'h0000, 4'h1);
    n = 0;
    while (midrail_ramping_o !== 1'b0 && n < 30000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    check(32'(n > 25300 && n < 25600), 32'h1);
    check(32'(midrail_ramp_level_o), 32'h0);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
